/* File: design/svt_top.sv */
// velocity and torque object block of the drive motion profile
`timescale 1ns/1ns
module svt_top #(
  parameter int unsigned MS_CYC = svt_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  // object access port
  input  wire logic                           obj_req,
  input  wire logic                           obj_wr,
  input  wire logic [svt_pkg::IDX_W-1:0]      obj_index,
  input  wire logic [svt_pkg::DAT_W-1:0]      obj_wdata,
  output logic      [svt_pkg::DAT_W-1:0]      obj_rdata_ff,
  output logic                                obj_ack_ff,
  output logic                                obj_err_ff,
  // drive state from the control loops
  input  wire logic                           ctl_tick,
  input  wire logic [7:0]                     op_mode,
  input  wire logic signed [31:0]             enc_speed,
  input  wire logic signed [31:0]             motor_speed,
  input  wire logic signed [31:0]             traj_speed,
  input  wire logic signed [31:0]             pos_ctrl_speed,
  input  wire logic                           pos_ctrl_active,
  // commands towards the control loops
  output logic signed [31:0]                  speed_cmd_ff,
  output logic signed [31:0]                  speed_ff_ff,
  output logic signed [15:0]                  torque_ff_ff,
  output logic signed [15:0]                  torque_ref_ff,
  // statusword bits 10 and 12
  output logic                                speed_reached,
  output logic                                speed_above
);
  import svt_pkg::*;

  localparam int unsigned MS_W = $clog2(MS_CYC + 1);

  // host-written objects
  logic [15:0]        match_width_ff,  nxt_match_width;
  logic [15:0]        match_delay_ff,  nxt_match_delay;
  logic [15:0]        limit_level_ff,  nxt_limit_level;
  logic [15:0]        limit_delay_ff,  nxt_limit_delay;
  logic signed [15:0] torque_cmd_ff,   nxt_torque_cmd;
  logic [31:0]        ramp_rate_ff,    nxt_ramp_rate;
  logic signed [31:0] speed_ofs_ff,    nxt_speed_ofs;
  logic signed [15:0] torque_ofs_ff,   nxt_torque_ofs;
  logic signed [31:0] speed_tgt_ff,    nxt_speed_tgt;
  // sampled drive values
  logic signed [31:0] enc_speed_ff,    nxt_enc_speed;
  logic signed [31:0] speed_dem_ff,    nxt_speed_dem;
  logic signed [31:0] act_speed_ff,    nxt_act_speed;
  // access answer
  logic [31:0]        nxt_rdata;
  logic               nxt_ack;
  logic               nxt_err;
  // outputs to the loops
  logic signed [31:0] nxt_speed_cmd;
  logic signed [31:0] nxt_speed_ff;
  logic signed [15:0] nxt_torque_ff;
  logic signed [15:0] nxt_torque_ref;
  // time base
  logic [MS_W-1:0]    ms_cnt_ff,       nxt_ms_cnt;
  logic               ms_tick_ff,      nxt_ms_tick;
  // decode and compare terms
  logic               hit;
  logic               writable;
  logic [31:0]        rd_val;
  logic               wr_go;
  logic               in_window;
  logic               above_limit;
  logic               ramp_en;
  logic signed [15:0] ramp_ref;
  logic [31:0]        spd_err;

  // ms divider feeding the qualification timers and the ramp
  always_comb begin
    nxt_ms_cnt  = ms_cnt_ff + MS_W'(1);
    nxt_ms_tick = 1'b0;
    if (ms_cnt_ff == MS_W'(MS_CYC - 1)) begin
      nxt_ms_cnt  = '0;
      nxt_ms_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_cnt_ff  <= '0;
      ms_tick_ff <= 1'b0;
    end else begin
      ms_cnt_ff  <= nxt_ms_cnt;
      ms_tick_ff <= nxt_ms_tick;
    end
  end

  // index decode; reads are pure, so polling never disturbs the loops
  always_comb begin
    hit      = 1'b1;
    writable = 1'b0;
    rd_val   = 32'h0;
    unique case (obj_index)
      IDX_SPEED_FROM_ENCODER:   rd_val = enc_speed_ff;
      IDX_SPEED_LOOP_REFERENCE: rd_val = speed_dem_ff;
      IDX_MOTOR_SPEED_NOW:      rd_val = act_speed_ff;
      IDX_SPEED_MATCH_WIDTH: begin
        rd_val   = {16'h0, match_width_ff};
        writable = 1'b1;
      end
      IDX_SPEED_MATCH_DELAY: begin
        rd_val   = {16'h0, match_delay_ff};
        writable = 1'b1;
      end
      IDX_SPEED_LIMIT_LEVEL: begin
        rd_val   = {16'h0, limit_level_ff};
        writable = 1'b1;
      end
      IDX_SPEED_LIMIT_DELAY: begin
        rd_val   = {16'h0, limit_delay_ff};
        writable = 1'b1;
      end
      IDX_TORQUE_COMMAND: begin
        rd_val   = {{16{torque_cmd_ff[15]}}, torque_cmd_ff};
        writable = 1'b1;
      end
      IDX_TORQUE_REFERENCE_OUT:
        rd_val = {{16{torque_ref_ff[15]}}, torque_ref_ff};
      IDX_TORQUE_OUTPUT_VALUE:
        rd_val = {{16{torque_ref_ff[15]}}, torque_ref_ff};
      IDX_TORQUE_RAMP_RATE: begin
        rd_val   = ramp_rate_ff;
        writable = 1'b1;
      end
      IDX_SPEED_FEEDFORWARD: begin
        rd_val   = speed_ofs_ff;
        writable = 1'b1;
      end
      IDX_TORQUE_FEEDFORWARD: begin
        rd_val   = {{16{torque_ofs_ff[15]}}, torque_ofs_ff};
        writable = 1'b1;
      end
      IDX_SPEED_COMMAND: begin
        rd_val   = speed_tgt_ff;
        writable = 1'b1;
      end
      default: hit = 1'b0;
    endcase
  end

  assign wr_go = obj_req && obj_wr && hit && writable;

  // answer every request one cycle later; unknown index or RO write errs
  always_comb begin
    nxt_ack   = obj_req;
    nxt_err   = obj_req && (!hit || (obj_wr && !writable));
    nxt_rdata = (obj_req && !obj_wr && hit) ? rd_val : 32'h0;
  end

  // object storage; 16-bit objects take the low half of the write word
  always_comb begin
    nxt_match_width = match_width_ff;
    nxt_match_delay = match_delay_ff;
    nxt_limit_level = limit_level_ff;
    nxt_limit_delay = limit_delay_ff;
    nxt_torque_cmd  = torque_cmd_ff;
    nxt_ramp_rate   = ramp_rate_ff;
    nxt_speed_ofs   = speed_ofs_ff;
    nxt_torque_ofs  = torque_ofs_ff;
    nxt_speed_tgt   = speed_tgt_ff;
    if (wr_go) begin
      unique case (obj_index)
        IDX_SPEED_MATCH_WIDTH: nxt_match_width = obj_wdata[15:0];
        IDX_SPEED_MATCH_DELAY: nxt_match_delay = obj_wdata[15:0];
        IDX_SPEED_LIMIT_LEVEL: nxt_limit_level = obj_wdata[15:0];
        IDX_SPEED_LIMIT_DELAY: nxt_limit_delay = obj_wdata[15:0];
        IDX_TORQUE_COMMAND:    nxt_torque_cmd  = obj_wdata[15:0];
        IDX_TORQUE_RAMP_RATE:  nxt_ramp_rate   = obj_wdata;
        IDX_SPEED_FEEDFORWARD: nxt_speed_ofs   = obj_wdata;
        IDX_TORQUE_FEEDFORWARD: nxt_torque_ofs = obj_wdata[15:0];
        IDX_SPEED_COMMAND:     nxt_speed_tgt   = obj_wdata;
        default: ;
      endcase
    end
  end

  // sample loop values once per control cycle so reads stay coherent
  always_comb begin
    nxt_enc_speed = enc_speed_ff;
    nxt_speed_dem = speed_dem_ff;
    nxt_act_speed = act_speed_ff;
    if (ctl_tick) begin
      nxt_enc_speed = enc_speed;
      nxt_act_speed = motor_speed;
      nxt_speed_dem = pos_ctrl_active ? pos_ctrl_speed : traj_speed;
    end
  end

  // mode-dependent commands; targets are taken as the host last wrote them
  always_comb begin
    nxt_speed_cmd  = 32'sh0;
    nxt_speed_ff   = 32'sh0;
    nxt_torque_ff  = 16'sh0;
    nxt_torque_ref = 16'sh0;
    if (op_mode == MODE_PV || op_mode == MODE_CSV)
      nxt_speed_cmd = speed_tgt_ff;
    if (op_mode == MODE_CSP)
      nxt_speed_ff = speed_ofs_ff;
    if (op_mode == MODE_CSP || op_mode == MODE_CSV)
      nxt_torque_ff = torque_ofs_ff;
    if (op_mode == MODE_CST)
      nxt_torque_ref = svt_sat16(torque_cmd_ff, torque_ofs_ff);
    else if (op_mode == MODE_PT)
      nxt_torque_ref = ramp_ref;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      match_width_ff <= RST_ZERO16;
      match_delay_ff <= RST_ZERO16;
      limit_level_ff <= RST_ZERO16;
      limit_delay_ff <= RST_ZERO16;
      torque_cmd_ff  <= RST_ZERO16;
      ramp_rate_ff   <= RST_RAMP_RATE;
      speed_ofs_ff   <= RST_ZERO32;
      torque_ofs_ff  <= RST_ZERO16;
      speed_tgt_ff   <= RST_ZERO32;
      enc_speed_ff   <= RST_ZERO32;
      speed_dem_ff   <= RST_ZERO32;
      act_speed_ff   <= RST_ZERO32;
      obj_rdata_ff   <= RST_ZERO32;
      obj_ack_ff     <= 1'b0;
      obj_err_ff     <= 1'b0;
      speed_cmd_ff   <= RST_ZERO32;
      speed_ff_ff    <= RST_ZERO32;
      torque_ff_ff   <= RST_ZERO16;
      torque_ref_ff  <= RST_ZERO16;
    end else begin
      match_width_ff <= nxt_match_width;
      match_delay_ff <= nxt_match_delay;
      limit_level_ff <= nxt_limit_level;
      limit_delay_ff <= nxt_limit_delay;
      torque_cmd_ff  <= nxt_torque_cmd;
      ramp_rate_ff   <= nxt_ramp_rate;
      speed_ofs_ff   <= nxt_speed_ofs;
      torque_ofs_ff  <= nxt_torque_ofs;
      speed_tgt_ff   <= nxt_speed_tgt;
      enc_speed_ff   <= nxt_enc_speed;
      speed_dem_ff   <= nxt_speed_dem;
      act_speed_ff   <= nxt_act_speed;
      obj_rdata_ff   <= nxt_rdata;
      obj_ack_ff     <= nxt_ack;
      obj_err_ff     <= nxt_err;
      speed_cmd_ff   <= nxt_speed_cmd;
      speed_ff_ff    <= nxt_speed_ff;
      torque_ff_ff   <= nxt_torque_ff;
      torque_ref_ff  <= nxt_torque_ref;
    end
  end

  // speed compares; threshold is taken on magnitude so reverse counts too
  assign spd_err     = svt_abs32(32'(speed_tgt_ff - act_speed_ff));
  assign in_window   = spd_err <= {16'h0, match_width_ff};
  assign above_limit = svt_abs32(act_speed_ff) > {16'h0, limit_level_ff};
  assign ramp_en     = (op_mode == MODE_PT);

  // speed reached qualification
  svt_qual_timer u_match_tmr (
    .clk     (clk),
    .rst_b   (rst_b),
    .cond    (in_window),
    .ms_tick (ms_tick_ff),
    .delay   (match_delay_ff),
    .flag_ff (speed_reached)
  );

  // speed above threshold qualification
  svt_qual_timer u_limit_tmr (
    .clk     (clk),
    .rst_b   (rst_b),
    .cond    (above_limit),
    .ms_tick (ms_tick_ff),
    .delay   (limit_delay_ff),
    .flag_ff (speed_above)
  );

  // profile torque ramp starts from the torque currently output
  svt_torque_ramp u_ramp (
    .clk      (clk),
    .rst_b    (rst_b),
    .en       (ramp_en),
    .ms_tick  (ms_tick_ff),
    .slope    (ramp_rate_ff),
    .target   (torque_cmd_ff),
    .load_val (torque_ref_ff),
    .ref_ff   (ramp_ref)
  );

  a_ack_next_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    obj_req |=> obj_ack_ff ##1 !obj_ack_ff || $past(obj_req))
    else $error("request not answered next cycle");
  a_ro_write_refused: assert property (@(posedge clk)
    disable iff (!rst_b)
    obj_req && obj_wr && obj_index == IDX_MOTOR_SPEED_NOW |=> obj_err_ff)
    else $error("write to read-only object accepted");
  a_speed_ff_mode: assert property (@(posedge clk) disable iff (!rst_b)
    op_mode == MODE_CSP ##1 $stable(speed_ofs_ff) |->
    speed_ff_ff == speed_ofs_ff)
    else $error("speed feedforward not applied");
  a_torque_ff_mode: assert property (@(posedge clk) disable iff (!rst_b)
    !(op_mode == MODE_CSP || op_mode == MODE_CSV) |=> torque_ff_ff == 16'sh0)
    else $error("torque feedforward outside its modes");
  a_cst_sum: assert property (@(posedge clk) disable iff (!rst_b)
    op_mode == MODE_CST |=>
    torque_ref_ff == svt_sat16($past(torque_cmd_ff), $past(torque_ofs_ff)))
    else $error("offset not added to torque reference");
  a_demand_src: assert property (@(posedge clk) disable iff (!rst_b)
    ctl_tick && pos_ctrl_active |=> speed_dem_ff == $past(pos_ctrl_speed))
    else $error("demand not from position controller");
  a_speed_cmd_mode: assert property (@(posedge clk) disable iff (!rst_b)
    op_mode == MODE_PV |=> speed_cmd_ff == $past(speed_tgt_ff))
    else $error("speed command not target velocity");
  a_read_actual: assert property (@(posedge clk) disable iff (!rst_b)
    obj_req && !obj_wr && obj_index == IDX_TORQUE_OUTPUT_VALUE |=>
    obj_rdata_ff[15:0] == $past(torque_ref_ff))
    else $error("torque actual differs from output");

  c_reached: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(speed_reached));
  c_above: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(speed_above));
  c_ramp: cover property (@(posedge clk) disable iff (!rst_b)
    ramp_en && torque_ref_ff != $past(torque_ref_ff));
endmodule

/* File: design/svt_pkg.sv */
// constants and helpers for the velocity and torque object block
package svt_pkg;
  // clock and qualification time base
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned QUAL_TICK_MS = 1;
  localparam int unsigned MS_CYCLES    = CLK_HZ / 1000 * QUAL_TICK_MS;
  // object access port widths
  localparam int unsigned IDX_W = 16;
  localparam int unsigned DAT_W = 32;
  // object indices
  localparam logic [15:0] IDX_SPEED_FROM_ENCODER   = 16'h6069;
  localparam logic [15:0] IDX_SPEED_LOOP_REFERENCE = 16'h606b;
  localparam logic [15:0] IDX_MOTOR_SPEED_NOW      = 16'h606c;
  localparam logic [15:0] IDX_SPEED_MATCH_WIDTH    = 16'h606d;
  localparam logic [15:0] IDX_SPEED_MATCH_DELAY    = 16'h606e;
  localparam logic [15:0] IDX_SPEED_LIMIT_LEVEL    = 16'h606f;
  localparam logic [15:0] IDX_SPEED_LIMIT_DELAY    = 16'h6070;
  localparam logic [15:0] IDX_TORQUE_COMMAND       = 16'h6071;
  localparam logic [15:0] IDX_TORQUE_REFERENCE_OUT = 16'h6074;
  localparam logic [15:0] IDX_TORQUE_OUTPUT_VALUE  = 16'h6077;
  localparam logic [15:0] IDX_TORQUE_RAMP_RATE     = 16'h6087;
  localparam logic [15:0] IDX_SPEED_FEEDFORWARD    = 16'h60b1;
  localparam logic [15:0] IDX_TORQUE_FEEDFORWARD   = 16'h60b2;
  localparam logic [15:0] IDX_SPEED_COMMAND        = 16'h60ff;
  // reset values
  localparam logic [31:0] RST_ZERO32      = 32'h0;
  localparam logic [15:0] RST_ZERO16      = 16'h0;
  localparam logic [31:0] RST_RAMP_RATE   = 32'h64;
  // operation mode codes
  localparam logic [7:0] MODE_PV  = 8'h03;
  localparam logic [7:0] MODE_PT  = 8'h04;
  localparam logic [7:0] MODE_CSP = 8'h08;
  localparam logic [7:0] MODE_CSV = 8'h09;
  localparam logic [7:0] MODE_CST = 8'h0a;
  // ramp budget: slope is per second, added per ms, one count costs this
  localparam logic [40:0] RAMP_COST = 41'h3e8;
  localparam int unsigned BUDGET_W  = 41;

  // magnitude of a signed 32-bit speed, saturating at the top
  function automatic logic [31:0] svt_abs32(input logic signed [31:0] v);
    if (v == 32'sh8000_0000) return 32'h7fff_ffff;
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  // signed 16-bit add with clamp at both ends
  function automatic logic signed [15:0] svt_sat16(
      input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [16:0] s;
    s = 17'(a) + 17'(b);
    if (s > 17'sh07fff) return 16'sh7fff;
    if (s < -17'sh08000) return 16'sh8000;
    return s[15:0];
  endfunction
endpackage

/* File: design/svt_qual_timer.sv */
// millisecond qualification timer for one speed status flag
`timescale 1ns/1ns
module svt_qual_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // compare result, time base and hold time in ms
  input  wire logic        cond,
  input  wire logic        ms_tick,
  input  wire logic [15:0] delay,
  // qualified flag
  output logic             flag_ff
);
  import svt_pkg::*;

  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        nxt_flag;

  // count whole ms while the compare holds, restart on any drop
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_flag = flag_ff;
    if (!cond) begin
      nxt_cnt  = RST_ZERO16;
      nxt_flag = 1'b0;
    end else if (cnt_ff >= delay) begin
      nxt_flag = 1'b1;
    end else if (ms_tick) begin
      nxt_cnt = cnt_ff + 16'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff  <= 16'h0;
      flag_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      flag_ff <= nxt_flag;
    end
  end

  a_flag_drops: assert property (@(posedge clk) disable iff (!rst_b)
    !cond |=> !flag_ff) else $error("flag stayed after compare dropped");
  a_flag_waits: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(flag_ff) |-> $past(cond) && ($past(cnt_ff) >= $past(delay)))
    else $error("flag rose before hold time");
endmodule

/* File: design/svt_torque_ramp.sv */
// torque ramp that walks one count at a time at a per-second rate
`timescale 1ns/1ns
module svt_torque_ramp (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // control
  input  wire logic               en,
  input  wire logic               ms_tick,
  input  wire logic        [31:0] slope,
  input  wire logic signed [15:0] target,
  input  wire logic signed [15:0] load_val,
  // ramp output
  output logic signed      [15:0] ref_ff
);
  import svt_pkg::*;

  logic        [BUDGET_W-1:0] budget_ff;
  logic        [BUDGET_W-1:0] nxt_budget;
  logic signed [15:0]         nxt_ref;
  logic        [BUDGET_W:0]   sum;

  // budget earns slope each ms and pays per count moved; no divider needed
  always_comb begin
    nxt_ref    = ref_ff;
    nxt_budget = budget_ff;
    sum        = {1'b0, budget_ff} + (ms_tick ? (BUDGET_W+1)'(slope) : '0);
    if (!en) begin
      nxt_ref    = load_val;
      nxt_budget = '0;
    end else if (ref_ff == target) begin
      nxt_budget = '0; // no stored credit, else a later step would jump
    end else begin
      if (sum[BUDGET_W]) sum = {1'b0, {BUDGET_W{1'b1}}};
      nxt_budget = sum[BUDGET_W-1:0];
      if (sum[BUDGET_W-1:0] >= RAMP_COST) begin
        nxt_budget = sum[BUDGET_W-1:0] - RAMP_COST;
        nxt_ref    = (ref_ff < target) ? ref_ff + 16'sh1 : ref_ff - 16'sh1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_ff    <= 16'sh0;
      budget_ff <= '0;
    end else begin
      ref_ff    <= nxt_ref;
      budget_ff <= nxt_budget;
    end
  end

  a_ramp_one_step: assert property (@(posedge clk) disable iff (!rst_b)
    en && $past(en) |-> (ref_ff - $past(ref_ff) <= 16'sh1) &&
    ($past(ref_ff) - ref_ff <= 16'sh1))
    else $error("ramp moved more than one count");
  a_ramp_zero_slope: assert property (@(posedge clk)
    disable iff (!rst_b)
    en && slope == 32'h0 && budget_ff == '0 |=> $stable(ref_ff) || !en)
    else $error("ramp moved with zero slope");
endmodule

/* File: sim/svt_host_model.sv */
// host controller model driving the object access port of the block
`timescale 1ns/1ns
module svt_host_model (
  // clock
  input  wire logic        clk,
  // request towards the device
  output logic             obj_req,
  output logic             obj_wr,
  output logic [15:0]      obj_index,
  output logic [31:0]      obj_wdata,
  // answer from the device
  input  wire logic [31:0] obj_rdata_ff,
  input  wire logic        obj_ack_ff,
  input  wire logic        obj_err_ff
);
  import svt_pkg::*;

  // idle port after time zero
  initial begin
    obj_req   = 1'b0;
    obj_wr    = 1'b0;
    obj_index = 16'h0;
    obj_wdata = 32'h0;
  end

  // one access entered just after a falling edge; the answer is taken
  // half a cycle after the request edge, then the lines are scrambled so a
  // stale index or data word can never pass for a held request; one
  // idle edge follows so a next call never re-drives req in that step
  task automatic access(input logic wr, input logic [15:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic ack, output logic err);
    obj_req   = 1'b1;
    obj_wr    = wr;
    obj_index = idx;
    obj_wdata = wd;
    @(posedge clk);
    @(negedge clk);
    rd        = obj_rdata_ff;
    ack       = obj_ack_ff;
    err       = obj_err_ff;
    obj_req   = 1'b0;
    obj_wr    = ~wr;
    obj_index = ~idx;
    obj_wdata = ~wd;
    @(negedge clk);
  endtask
endmodule

/* File: sim/test_servo_velocity_torque_objects.sv */
// self-checking bench for the velocity and torque object block
`timescale 1ns/1ns
module test_servo_velocity_torque_objects;
  import svt_pkg::*;
  localparam int unsigned MSC    = 10;  // cycles per ms, shortened
  localparam int unsigned INTERP = 20;  // scaled interpolation period
  logic               clk, rst_b, obj_req, obj_wr, obj_ack_ff, obj_err_ff;
  logic               ctl_tick, pos_ctrl_active, speed_reached, speed_above;
  logic        [15:0] obj_index;
  logic        [31:0] obj_wdata, obj_rdata_ff, rd, e_enc, e_mot, e_dem;
  logic         [7:0] op_mode;
  logic signed [31:0] enc_speed, motor_speed, traj_speed, pos_ctrl_speed;
  logic signed [31:0] speed_cmd_ff, speed_ff_ff;
  logic signed [15:0] torque_ff_ff, torque_ref_ff;
  logic               ack, err;
  int                 num_errors, n_compared, n;
  logic        [15:0] rw_idx [9] = '{16'h606d, 16'h606e, 16'h606f, 16'h6070,
    16'h6071, 16'h6087, 16'h60b1, 16'h60b2, 16'h60ff};
  logic        [15:0] ro_idx [5] = '{16'h6069, 16'h606b, 16'h606c, 16'h6074,
    16'h6077};
  logic         [7:0] modes  [4] = '{MODE_PV, MODE_CSP, MODE_CSV, MODE_CST};

  svt_top #(.MS_CYC(MSC)) DUT (.clk(clk), .rst_b(rst_b), .obj_req(obj_req),
    .obj_wr(obj_wr), .obj_index(obj_index), .obj_wdata(obj_wdata),
    .obj_rdata_ff(obj_rdata_ff), .obj_ack_ff(obj_ack_ff),
    .obj_err_ff(obj_err_ff), .ctl_tick(ctl_tick), .op_mode(op_mode),
    .enc_speed(enc_speed), .motor_speed(motor_speed),
    .traj_speed(traj_speed), .pos_ctrl_speed(pos_ctrl_speed),
    .pos_ctrl_active(pos_ctrl_active), .speed_cmd_ff(speed_cmd_ff),
    .speed_ff_ff(speed_ff_ff), .torque_ff_ff(torque_ff_ff),
    .torque_ref_ff(torque_ref_ff), .speed_reached(speed_reached),
    .speed_above(speed_above));
  svt_host_model host (.clk(clk), .obj_req(obj_req), .obj_wr(obj_wr),
    .obj_index(obj_index), .obj_wdata(obj_wdata),
    .obj_rdata_ff(obj_rdata_ff), .obj_ack_ff(obj_ack_ff),
    .obj_err_ff(obj_err_ff));

  // compare and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one access with its answer code checked; read data lands in rd
  task automatic rw(input logic wr, input logic [15:0] idx,
                    input logic [31:0] wd, input logic exp_err);
    host.access(wr, idx, wd, rd, ack, err);
    check("ack", {31'h0, ack}, 32'h1);
    check("err", {31'h0, err}, {31'h0, exp_err});
  endtask

  // read-back form: signed 16-bit widen by sign, unsigned by zeros
  function automatic logic [31:0] rb(input logic [15:0] i,
                                     input logic [31:0] w);
    if (i == 16'h6071 || i == 16'h60b2) return {{16{w[15]}}, w[15:0]};
    if (i >= 16'h606d && i <= 16'h6070) return {16'h0, w[15:0]};
    return w;
  endfunction

  // clamped torque sum, worked out independently of the design
  function automatic logic [31:0] sat(input logic signed [15:0] a,
                                      input logic signed [15:0] b);
    int s;
    s = int'(a) + int'(b);
    if (s > 32767) s = 32767;
    if (s < -32768) s = -32768;
    return 32'(s);
  endfunction

  // control cycle strobe; inputs scrambled after it to prove sampling
  task automatic tick(input logic [31:0] m);
    enc_speed       = $urandom;
    motor_speed     = m;
    traj_speed      = $urandom;
    pos_ctrl_speed  = $urandom;
    pos_ctrl_active = 1'($urandom);
    ctl_tick        = 1'b1;
    @(negedge clk);
    ctl_tick = 1'b0;
    e_enc    = enc_speed;
    e_mot    = motor_speed;
    e_dem    = pos_ctrl_active ? pos_ctrl_speed : traj_speed;
    {enc_speed, motor_speed, traj_speed} = ~{enc_speed, m, traj_speed};
    pos_ctrl_speed = ~pos_ctrl_speed;
  endtask

  // load targets, then visit PV, CSP, CSV and CST for one interpolation period each
  task automatic modes_pass(input logic [31:0] ts, input logic [31:0] vo,
                            input logic [15:0] tt, input logic [15:0] to);
    logic [7:0] m;
    rw(1'b1, IDX_SPEED_COMMAND, ts, 1'b0);
    rw(1'b1, IDX_SPEED_FEEDFORWARD, vo, 1'b0);
    rw(1'b1, IDX_TORQUE_COMMAND, {16'h0, tt}, 1'b0);
    rw(1'b1, IDX_TORQUE_FEEDFORWARD, {16'h0, to}, 1'b0);
    for (int k = 0; k < 4; k++) begin
      m       = modes[k];
      op_mode = m;
      repeat (INTERP) @(negedge clk);
      check("speed_cmd", speed_cmd_ff,
            (m == MODE_PV || m == MODE_CSV) ? ts : 32'h0);
      check("speed_ff", speed_ff_ff, (m == MODE_CSP) ? vo : 32'h0);
      check("torque_ff", 32'(torque_ff_ff),
            (m == MODE_CSP || m == MODE_CSV) ? rb(16'h60b2, to) : 0);
      check("torque_ref", 32'(torque_ref_ff),
            (m == MODE_CST) ? sat(tt, to) : 32'h0);
      rw(1'b0, IDX_TORQUE_REFERENCE_OUT, 32'h0, 1'b0);
      check("demand", rd, (m == MODE_CST) ? sat(tt, to) : 32'h0);
      rw(1'b0, IDX_TORQUE_OUTPUT_VALUE, 32'h0, 1'b0);
      check("actual", rd, (m == MODE_CST) ? sat(tt, to) : 32'h0);
    end
  endtask

  // counts, verdict and end of run
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    {rst_b, ctl_tick, pos_ctrl_active, op_mode} = '0;
    {enc_speed, motor_speed, traj_speed, pos_ctrl_speed} = '0;
    num_errors = 0;
    n_compared = 0;
    void'($urandom(8));
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    // reset values, then random write and read-back
    foreach (rw_idx[i]) begin
      rw(1'b0, rw_idx[i], 32'h0, 1'b0);
      check("reset", rd, (rw_idx[i] == IDX_TORQUE_RAMP_RATE) ?
            RST_RAMP_RATE : RST_ZERO32);
    end
    foreach (rw_idx[i]) begin
      logic [31:0] w;
      w = $urandom;
      rw(1'b1, rw_idx[i], w, 1'b0);
      rw(1'b0, rw_idx[i], 32'h0, 1'b0);
      check("readback", rd, rb(rw_idx[i], w));
    end
    // read-only objects refuse writes and keep their value
    foreach (ro_idx[i]) begin
      rw(1'b1, ro_idx[i], 32'h5a5a_a5a5, 1'b1);
      rw(1'b0, ro_idx[i], 32'h0, 1'b0);
      check("ro kept", rd, 32'h0);
    end
    rw(1'b1, 16'h6072, 32'h1, 1'b1);
    rw(1'b0, 16'h6068, 32'h0, 1'b1);
    // drive values sampled on the control strobe, reads repeatable
    for (int k = 0; k < 6; k++) begin
      tick($urandom);
      for (int j = 0; j < 2; j++) begin
        rw(1'b0, IDX_SPEED_FROM_ENCODER, 32'h0, 1'b0);
        check("encoder", rd, e_enc);
        rw(1'b0, IDX_MOTOR_SPEED_NOW, 32'h0, 1'b0);
        check("motor", rd, e_mot);
        rw(1'b0, IDX_SPEED_LOOP_REFERENCE, 32'h0, 1'b0);
        check("demand", rd, e_dem);
      end
    end
    // mode outputs: random pass, then both clamp ends
    modes_pass($urandom, $urandom, 16'($urandom), 16'($urandom));
    modes_pass(32'h8000_0000, 32'h7fff_ffff, 16'h7fff, 16'h0010);
    modes_pass(32'h1, 32'hffff_ffff, 16'h8000, 16'hfff0);
    // profile ramp: 2000 per second is two counts per ms up to ten
    op_mode = MODE_PV;
    rw(1'b1, IDX_TORQUE_COMMAND, 32'ha, 1'b0);
    rw(1'b1, IDX_TORQUE_RAMP_RATE, 32'h7d0, 1'b0);
    op_mode = MODE_PT;
    repeat (3 * MSC) @(negedge clk);
    check("ramp early", {31'h0, torque_ref_ff <= 16'sh8}, 32'h1);
    repeat (4 * MSC) @(negedge clk);
    check("ramp end", 32'(torque_ref_ff), 32'ha);
    // zero slope holds the output although the target moves away
    rw(1'b1, IDX_TORQUE_RAMP_RATE, 32'h0, 1'b0);
    rw(1'b1, IDX_TORQUE_COMMAND, 32'h14, 1'b0);
    repeat (3 * MSC) @(negedge clk);
    check("ramp held", 32'(torque_ref_ff), 32'ha);
    // both status flags qualified over three ms, then dropped
    op_mode = MODE_CSV;
    rw(1'b1, IDX_SPEED_MATCH_WIDTH, 32'ha, 1'b0);
    rw(1'b1, IDX_SPEED_LIMIT_LEVEL, 32'h1f4, 1'b0);
    rw(1'b1, IDX_SPEED_COMMAND, 32'h3e8, 1'b0);
    tick(32'h0); // both compares false, so stale counts are cleared
    rw(1'b1, IDX_SPEED_MATCH_DELAY, 32'h3, 1'b0);
    rw(1'b1, IDX_SPEED_LIMIT_DELAY, 32'h3, 1'b0);
    tick(32'h3e9);
    repeat (2 * MSC) @(negedge clk);
    check("reached early", {31'h0, speed_reached}, 32'h0);
    check("above early", {31'h0, speed_above}, 32'h0);
    for (n = 0; n < 2 * MSC + 6 && !(speed_reached === 1'b1 &&
         speed_above === 1'b1); n++) @(negedge clk);
    check("reached", {31'h0, speed_reached}, 32'h1);
    check("above", {31'h0, speed_above}, 32'h1);
    tick(32'h0);
    repeat (3) @(negedge clk);
    check("reached drop", {31'h0, speed_reached}, 32'h0);
    check("above drop", {31'h0, speed_above}, 32'h0);
    print_verdict();
  end
endmodule
